// ==== logic/tmc_pkg.sv ====
// Package for the tone and mode control block: register map, field
// positions, reset values and tone divider figures.
// Assumes a single 32-bit AHB-Lite slave port with one aligned word
// for each register.
package tmc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL1  = 8'h04;  // Video de-emphasis pin function
  localparam logic [7:0] OFS_CTRL2  = 8'h08;  // Reference clock selection
  localparam logic [7:0] OFS_CTRL3  = 8'h0c;  // Tone enable
  localparam logic [7:0] OFS_CTRL4  = 8'h10;  // Stand-by selection
  localparam logic [7:0] OFS_CTRL5  = 8'h14;  // I/O pin configuration, high and low bits
  localparam logic [7:0] OFS_CTRL6  = 8'h18;  // I/O pin general purpose direction and driven level
  localparam logic [7:0] OFS_OUTEN  = 8'h1c;  // Output stage enables
  localparam logic [7:0] OFS_STATUS = 8'h20;  // Read-only status

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DEEMPH_PIN_FUNCTION_BIT = 7;  // Control 1
  localparam int REF_CLOCK_SELECT_BIT    = 3;  // Control 2, high = 8 MHz
  localparam int TONE_ENABLE_BIT         = 3;  // Control 3
  localparam int STANDBY_SELECT_BIT      = 3;  // Control 4, high = stand-by
  localparam int IO_PIN_CFG_HI_BIT       = 7;  // Control 5
  localparam int IO_PIN_CFG_LO_BIT       = 6;  // Control 5
  localparam int IO_PIN_DIR_BIT          = 0;  // Control 6, high = output
  localparam int IO_PIN_VALUE_BIT        = 1;  // Control 6, driven level
  localparam int STAT_IO_IN_BIT          = 0;
  localparam int STAT_STANDBY_BIT        = 1;
  localparam int STAT_TONE_BIT           = 2;
  localparam int STAT_SUPPLY_OK_BIT      = 3;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTRL    = 8'h00;
  localparam int         OUT_STAGES  = 4;
  localparam logic [3:0] RST_OUTEN   = 4'h0;   // All output stages high impedance
  localparam int         SYNC_STAGES = 3;

  // ----------------------------------------------------------------
  // Tone divider: 4 MHz / 180 = 8 MHz / 360 = 22.22 kHz
  // ----------------------------------------------------------------
  localparam int TONE_DIV_4M = 180;
  localparam int TONE_DIV_8M = 360;

  // ----------------------------------------------------------------
  // Bus encodings and pin modes
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  typedef enum logic [1:0] {
    TMC_IO_GPIO  = 2'h0,
    TMC_IO_TONE  = 2'h1,
    TMC_IO_RESET = 2'h3
  } tmc_io_mode_t;

endpackage : tmc_pkg

// ==== logic/tmc_tone_div.sv ====
// Tone divider: counts reference clock edges and toggles the tone.
// Assumes ref_edge is a one-cycle pulse on hclk per reference rising edge.
`timescale 1ns/10ps
module tmc_tone_div
  import tmc_pkg::*;
#(
  parameter int CNT_W = 9
)(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic clear,
  input  wire logic ref_edge,
  input  wire logic div_8m,
  output logic      tone
);

  localparam logic [CNT_W-1:0] HALF_4M = CNT_W'(TONE_DIV_4M / 2);
  localparam logic [CNT_W-1:0] HALF_8M = CNT_W'(TONE_DIV_8M / 2);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             tone_ff;
  logic             nxt_tone;
  logic [CNT_W-1:0] half;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // Half period in reference edges, then toggle for 50 percent duty
  always_comb
  begin
    half     = div_8m ? HALF_8M : HALF_4M;
    nxt_cnt  = cnt_ff;
    nxt_tone = tone_ff;
    if (clear)
    begin
      nxt_cnt  = '0;
      nxt_tone = 1'b0;
    end
    else if (ref_edge)
    begin
      if (cnt_ff >= half - CNT_W'(1))
      begin
        nxt_cnt  = '0;
        nxt_tone = ~tone_ff;
      end
      else
      begin
        nxt_cnt = cnt_ff + CNT_W'(1);
      end
    end
  end

  // Register the divider state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_ff  <= '0;
      tone_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      tone_ff <= nxt_tone;
    end
  end

  assign tone = tone_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  tone_toggle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ($changed(tone_ff) && !$past(clear)) |->
      ($past(ref_edge) && ($past(cnt_ff) >= $past(half) - CNT_W'(1))))
    else $error("Tone toggled away from the half period");

  tone_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ref_edge && !clear) |=> (cnt_ff < $past(half)))
    else $error("Tone counter ran past the half period");

endmodule : tmc_tone_div

// ==== logic/tmc_top.sv ====
// Tone and mode control: AHB-Lite control registers, supply fault reset,
// stand-by, reference clock selection, tone generator and I/O pin.
// Assumes supply good levels, the reference clock and the I/O pin input
// arrive asynchronously to hclk and are sampled here.
`timescale 1ns/10ps

// How it works
// - A faulty supply holds the internal reset, clears every register and stops the bus decoder.
// - The I/O pin shows the internal reset, active high, for its first cycle only when config high is set and low is clear; the fault clears control 5.
// - Software enters or leaves stand-by with the stand-by bit and the block follows it.
// - In stand-by the decoder, audio matrix and video clamp and matrix stay powered.
// - The reference select bit tells whether the clock is 4 or 8 MHz and timing scales with it.
// - The 22.22 kHz tone comes from dividing the reference clock.
// - The tone goes to the de-emphasis pin or to the I/O pin by the register settings.
// - The I/O pin acts as a general input or output set by control 5 and control 6.
// - After reset every audio and video output stage is high impedance until enabled.
module tmc_top
  import tmc_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic                  supply5_ok,
  input  wire logic                  supply12_ok,
  input  wire logic                  crystal_clock_pin,
  input  wire logic                  io_pin_in,
  output logic                       io_pin_out,
  output logic                       io_pin_oe_n,
  output logic                       deemph_tone_pin,
  output logic                       internal_reset,
  output logic                       standby_mode,
  output logic                       ref_clock_8m,
  output logic                       analog_power_en,
  output logic                       matrix_power_en,
  output logic      [OUT_STAGES-1:0] out_stage_en
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 4;  // supply5, supply12, reference clock, I/O pin

  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] filt_ff;
  logic [NSYNC-1:0] nxt_filt;
  logic             ref_prev_ff;
  logic             fault;
  logic             ref_edge;

  assign async_in = {io_pin_in, crystal_clock_pin, supply12_ok, supply5_ok};

  // Three flops per input; a level counts once stages two and three agree
  for (genvar i = 0; i < NSYNC; i++)
  begin : g_sync
    logic [SYNC_STAGES-1:0] sh_ff;
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        sh_ff <= '0;
      end
      else
      begin
        sh_ff <= {sh_ff[SYNC_STAGES-2:0], async_in[i]};
      end
    end
    assign nxt_filt[i] = (sh_ff[1] == sh_ff[2]) ? sh_ff[2] : filt_ff[i];
  end

  // Filtered levels and reference edge history
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      filt_ff     <= '0;
      ref_prev_ff <= 1'b0;
    end
    else
    begin
      filt_ff     <= nxt_filt;
      ref_prev_ff <= filt_ff[2];
    end
  end

  assign fault    = ~(filt_ff[0] & filt_ff[1]);
  assign ref_edge = filt_ff[2] & ~ref_prev_ff;

  // ----------------------------------------------------------------
  // AHB-Lite slave and control registers
  // ----------------------------------------------------------------
  logic [7:0]            ctrl_ff [1:6];
  logic [7:0]            nxt_ctrl [1:6];
  logic [OUT_STAGES-1:0] outen_ff;
  logic [OUT_STAGES-1:0] nxt_outen;
  logic                  wr_pend_ff;
  logic                  nxt_wr_pend;
  logic [7:0]            wr_addr_ff;
  logic [7:0]            nxt_wr_addr;
  logic [31:0]           hrdata_ff;
  logic [31:0]           nxt_hrdata;
  logic                  acc;
  logic                  tone;

  // Address phase accepted; hsize is not checked, every access is a word
  assign acc = hsel & hready & (htrans == HTRANS_NONSEQ) & (haddr[31:8] == 24'h0);

  // Next register values, write commit and read data from updated values
  always_comb
  begin
    for (int r = 1; r <= 6; r++)
    begin
      nxt_ctrl[r] = ctrl_ff[r];
    end
    nxt_outen   = outen_ff;
    nxt_wr_pend = acc & hwrite & ~fault;
    nxt_wr_addr = acc ? haddr[7:0] : wr_addr_ff;
    nxt_hrdata  = 32'h0;
    if (fault)
    begin
      for (int r = 1; r <= 6; r++)
      begin
        nxt_ctrl[r] = RST_CTRL;
      end
      nxt_outen = RST_OUTEN;
    end
    else if (wr_pend_ff)
    begin
      unique case (wr_addr_ff)
        OFS_CTRL1: nxt_ctrl[1] = hwdata[7:0];
        OFS_CTRL2: nxt_ctrl[2] = hwdata[7:0];
        OFS_CTRL3: nxt_ctrl[3] = hwdata[7:0];
        OFS_CTRL4: nxt_ctrl[4] = hwdata[7:0];
        OFS_CTRL5: nxt_ctrl[5] = hwdata[7:0];
        OFS_CTRL6: nxt_ctrl[6] = hwdata[7:0];
        OFS_OUTEN: nxt_outen   = hwdata[OUT_STAGES-1:0];
        default:   nxt_outen   = outen_ff;
      endcase
    end
    if (acc && !hwrite && !fault)
    begin
      unique case (haddr[7:0])
        OFS_CTRL1:  nxt_hrdata = {24'h0, nxt_ctrl[1]};
        OFS_CTRL2:  nxt_hrdata = {24'h0, nxt_ctrl[2]};
        OFS_CTRL3:  nxt_hrdata = {24'h0, nxt_ctrl[3]};
        OFS_CTRL4:  nxt_hrdata = {24'h0, nxt_ctrl[4]};
        OFS_CTRL5:  nxt_hrdata = {24'h0, nxt_ctrl[5]};
        OFS_CTRL6:  nxt_hrdata = {24'h0, nxt_ctrl[6]};
        OFS_OUTEN:  nxt_hrdata = {{(32-OUT_STAGES){1'b0}}, nxt_outen};
        OFS_STATUS:
        begin
          nxt_hrdata[STAT_IO_IN_BIT]     = filt_ff[3];
          nxt_hrdata[STAT_STANDBY_BIT]   = ctrl_ff[4][STANDBY_SELECT_BIT];
          nxt_hrdata[STAT_TONE_BIT]      = tone;
          nxt_hrdata[STAT_SUPPLY_OK_BIT] = ~fault;
        end
        default:    nxt_hrdata = 32'h0;                  // Unmapped reads zero
      endcase
    end
  end

  // Register file and bus state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int r = 1; r <= 6; r++)
      begin
        ctrl_ff[r] <= RST_CTRL;
      end
      outen_ff   <= RST_OUTEN;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff  <= 32'h0;
    end
    else
    begin
      for (int r = 1; r <= 6; r++)
      begin
        ctrl_ff[r] <= nxt_ctrl[r];
      end
      outen_ff   <= nxt_outen;
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      hrdata_ff  <= nxt_hrdata;
    end
  end

  // Zero wait states, always OKAY
  assign hrdata    = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;

  // ----------------------------------------------------------------
  // Tone generator
  // ----------------------------------------------------------------
  logic standby;
  logic div_8m;

  assign standby = ctrl_ff[4][STANDBY_SELECT_BIT];
  assign div_8m  = ctrl_ff[2][REF_CLOCK_SELECT_BIT];

  // Tone is not kept alive in stand-by, so the divider stops there
  tmc_tone_div #(
    .CNT_W (9)
  ) u_tone (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .clear    (fault | standby),
    .ref_edge (ref_edge),
    .div_8m   (div_8m),
    .tone     (tone)
  );

  // ----------------------------------------------------------------
  // Pin and power outputs
  // ----------------------------------------------------------------
  tmc_io_mode_t io_mode;
  logic io_out_ff;
  logic nxt_io_out;
  logic io_oe_n_ff;
  logic nxt_io_oe_n;
  logic deemph_ff;
  logic nxt_deemph;
  logic rst_ff;
  logic standby_ff;
  logic ref8_ff;
  logic apwr_ff;
  logic nxt_apwr;
  logic mpwr_ff;
  logic [OUT_STAGES-1:0] stage_ff;

  // Decode the pin function and compute every pin level
  always_comb
  begin
    if (ctrl_ff[5][IO_PIN_CFG_LO_BIT])
    begin
      io_mode = TMC_IO_TONE;
    end
    else if (ctrl_ff[5][IO_PIN_CFG_HI_BIT])
    begin
      io_mode = TMC_IO_RESET;
    end
    else
    begin
      io_mode = TMC_IO_GPIO;
    end
    nxt_io_out  = 1'b0;
    nxt_io_oe_n = 1'b1;
    unique case (io_mode)
      TMC_IO_TONE:
      begin
        nxt_io_out  = tone;
        nxt_io_oe_n = 1'b0;
      end
      TMC_IO_RESET:
      begin
        nxt_io_out  = fault;
        nxt_io_oe_n = 1'b0;
      end
      TMC_IO_GPIO:
      begin
        nxt_io_out  = ctrl_ff[6][IO_PIN_VALUE_BIT];
        nxt_io_oe_n = ~ctrl_ff[6][IO_PIN_DIR_BIT];
      end
    endcase
    nxt_deemph = ctrl_ff[3][TONE_ENABLE_BIT] & ~ctrl_ff[1][DEEMPH_PIN_FUNCTION_BIT]
                 & tone;
    nxt_apwr   = ~standby & ~fault;
  end

  // Every pin and power output leaves from a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      io_out_ff  <= 1'b0;
      io_oe_n_ff <= 1'b1;
      deemph_ff  <= 1'b0;
      rst_ff     <= 1'b1;
      standby_ff <= 1'b0;
      ref8_ff    <= 1'b0;
      apwr_ff    <= 1'b0;
      mpwr_ff    <= 1'b0;
      stage_ff   <= RST_OUTEN;
    end
    else
    begin
      io_out_ff  <= nxt_io_out;
      io_oe_n_ff <= nxt_io_oe_n;
      deemph_ff  <= nxt_deemph;
      rst_ff     <= fault;
      standby_ff <= standby;
      ref8_ff    <= div_8m;
      apwr_ff    <= nxt_apwr;
      mpwr_ff    <= ~fault;
      stage_ff   <= outen_ff;
    end
  end

  assign io_pin_out      = io_out_ff;
  assign io_pin_oe_n     = io_oe_n_ff;
  assign deemph_tone_pin = deemph_ff;
  assign internal_reset  = rst_ff;
  assign standby_mode    = standby_ff;
  assign ref_clock_8m    = ref8_ff;
  assign analog_power_en = apwr_ff;
  assign matrix_power_en = mpwr_ff;
  assign out_stage_en    = stage_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence standby_write_s;
    (acc && hwrite && haddr[7:0] == OFS_CTRL4) ##1
    (hwdata[STANDBY_SELECT_BIT] && !fault) ##1 !fault;
  endsequence

  fault_clears_a: assert property (fault |=>
    (ctrl_ff[4] == RST_CTRL && ctrl_ff[5] == RST_CTRL && outen_ff == RST_OUTEN))
    else $error("Supply fault did not clear the registers");
  fault_no_write_a: assert property (fault |=> !wr_pend_ff)
    else $error("Bus write accepted during supply fault");
  io_reset_a: assert property ((io_mode == TMC_IO_RESET) |=>
    (io_pin_out == $past(fault) && !io_pin_oe_n))
    else $error("I/O pin does not show the internal reset");
  standby_entry_a: assert property (standby_write_s |=>
    (standby_mode && !analog_power_en))
    else $error("Stand-by write not followed");
  standby_alive_a: assert property ((standby && !fault) |=> matrix_power_en)
    else $error("Matrix power lost in stand-by");
  ref_select_a: assert property ($rose(div_8m) |=> ref_clock_8m)
    else $error("Reference select not applied");
  tone_route_a: assert property ((ctrl_ff[3][TONE_ENABLE_BIT] &&
    !ctrl_ff[1][DEEMPH_PIN_FUNCTION_BIT]) |=> deemph_tone_pin == $past(tone))
    else $error("Tone missing on the de-emphasis pin");
  io_gpio_a: assert property ((io_mode == TMC_IO_GPIO) |=>
    (io_pin_oe_n == !$past(ctrl_ff[6][IO_PIN_DIR_BIT])))
    else $error("I/O pin direction wrong");
  stage_enable_a: assert property (($changed(outen_ff) && outen_ff != RST_OUTEN) |->
    $past(wr_pend_ff && wr_addr_ff == OFS_OUTEN))
    else $error("Output stage enabled without a write");

endmodule : tmc_top

// ==== tb/testbench.sv ====
// Testbench: AHB-Lite register accesses driving the tone and mode control.
// Assumes a zero wait state slave and a reference clock of 80 ns period.
`timescale 1ns/10ps
module testbench
  import tmc_pkg::*;
;
  localparam int LIMIT = 60000;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0]  htrans;
  logic        supply5_ok, supply12_ok, crystal_clock_pin, io_pin_in, io_pin_out;
  logic        io_pin_oe_n, deemph_tone_pin, internal_reset, standby_mode;
  logic        ref_clock_8m, analog_power_en, matrix_power_en, ext_en, ext_level;
  logic        pick, tone_obs, saw_pin;
  logic [3:0]  out_stage_en;
  logic [7:0]  regs [7];
  int          fail_count, checked, cycles, half, n;

  assign hready   = hreadyout;
  assign tone_obs = pick ? io_pin_out : deemph_tone_pin;

  tmc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .supply5_ok(supply5_ok),
    .supply12_ok(supply12_ok), .crystal_clock_pin(crystal_clock_pin),
    .io_pin_in(io_pin_in), .io_pin_out(io_pin_out), .io_pin_oe_n(io_pin_oe_n),
    .deemph_tone_pin(deemph_tone_pin), .internal_reset(internal_reset),
    .standby_mode(standby_mode), .ref_clock_8m(ref_clock_8m),
    .analog_power_en(analog_power_en), .matrix_power_en(matrix_power_en),
    .out_stage_en(out_stage_en));

  tmc_far_side #(.REF_NS(80)) far (.crystal_clock_pin(crystal_clock_pin),
    .io_pin_out(io_pin_out), .io_pin_oe_n(io_pin_oe_n), .ext_en(ext_en),
    .ext_level(ext_level), .io_pin_in(io_pin_in));

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  always #5 hclk = ~hclk;

  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One single AHB transfer; starts and ends just after a rising edge
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    check(hresp, HRESP_OKAY);
  endtask : xfer

  task settle();
    repeat (4) @(posedge hclk);
  endtask : settle

  // Cycles between two successive changes of the observed tone
  task measure(output int h);
    logic v;
    int   k;
    v = tone_obs;
    k = 0;
    while (tone_obs === v && k < 4000)
    begin
      @(posedge hclk);
      k++;
    end
    v = tone_obs;
    k = 0;
    while (tone_obs === v && k < 4000)
    begin
      @(posedge hclk);
      k++;
    end
    h = k;
  endtask : measure

  task tally_and_finish();
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
    supply5_ok = 1; supply12_ok = 1; ext_en = 1; ext_level = 0; pick = 0;
    fail_count = 0; checked = 0; cycles = 0;
    regs = '{OFS_CTRL1, OFS_CTRL2, OFS_CTRL3, OFS_CTRL4, OFS_CTRL5, OFS_CTRL6, OFS_OUTEN};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    // Defaults, outputs high impedance, unmapped place
    check(out_stage_en, 4'h0);
    check(internal_reset, 1'b0);
    for (int i = 0; i < 7; i++)
    begin
      xfer(0, regs[i], 0, rv);
      check(rv, 32'h0);
      xfer(1, regs[i], 32'hffffffff, rv);
      xfer(0, regs[i], 0, rv);
      check(rv, (i == 6) ? 32'hf : 32'hff);
      xfer(1, regs[i], 0, rv);
    end
    xfer(1, 8'h40, 32'h5a, rv);
    xfer(0, 8'h40, 0, rv);
    check(rv, 32'h0);
    xfer(1, OFS_OUTEN, 32'hf, rv);
    settle();
    check(out_stage_en, 4'hf);
    // Stand-by keeps the decoder and matrices alive
    xfer(1, OFS_CTRL4, 32'h8, rv);
    settle();
    check({standby_mode, analog_power_en, matrix_power_en}, 3'b101);
    xfer(0, OFS_STATUS, 0, rv);
    check(rv, 32'ha);
    xfer(1, OFS_CTRL4, 32'h0, rv);
    settle();
    check({standby_mode, analog_power_en, matrix_power_en}, 3'b011);
    // Tone half period in both reference modes on the de-emphasis pin
    xfer(1, OFS_CTRL3, 32'h8, rv);
    for (int m = 0; m < 2; m++)
    begin
      xfer(1, OFS_CTRL2, m << 3, rv);
      settle();
      check(ref_clock_8m, m[0]);
      measure(half);
      measure(half);
      check(half, 720 * (m + 1));
    end
    xfer(1, OFS_CTRL1, 32'h80, rv);
    repeat (1500) @(posedge hclk);
    check(deemph_tone_pin, 1'b0);
    // Tone on the I/O pin, then stopped by stand-by
    pick = 1;
    xfer(1, OFS_CTRL5, 32'h40, rv);
    measure(half);
    measure(half);
    check(half, 1440);
    check(io_pin_oe_n, 1'b0);
    xfer(1, OFS_CTRL4, 32'h8, rv);
    repeat (1500) @(posedge hclk);
    check(io_pin_out, 1'b0);
    xfer(1, OFS_CTRL4, 32'h0, rv);
    // General purpose output and input
    xfer(1, OFS_CTRL5, 32'h0, rv);
    xfer(1, OFS_CTRL6, 32'h3, rv);
    settle();
    check({io_pin_oe_n, io_pin_out}, 2'b01);
    xfer(1, OFS_CTRL6, 32'h2, rv);
    for (int l = 1; l >= 0; l--)
    begin
      ext_level <= l[0];
      repeat (8) @(posedge hclk);
      check(io_pin_oe_n, 1'b1);
      xfer(0, OFS_STATUS, 0, rv);
      check(rv, 32'h8 | l);
    end
    // Supply fault on each rail
    for (int s = 0; s < 2; s++)
    begin
      xfer(1, OFS_CTRL5, 32'h80, rv);
      xfer(1, OFS_OUTEN, 32'hf, rv);
      settle();
      check({io_pin_oe_n, io_pin_out}, 2'b00);
      if (s == 0) supply5_ok <= 1'b0;
      else supply12_ok <= 1'b0;
      saw_pin = 0;
      n = 0;
      while (internal_reset !== 1'b1 && n < 20)
      begin
        @(posedge hclk);
        n++;
        if (io_pin_out === 1'b1 && io_pin_oe_n === 1'b0) saw_pin = 1;
      end
      settle();
      check(internal_reset, 1'b1);
      check(saw_pin, 1'b1);
      check({out_stage_en, analog_power_en, matrix_power_en}, 6'h0);
      xfer(1, OFS_CTRL4, 32'h8, rv);
      xfer(0, OFS_CTRL3, 0, rv);
      check(rv, 32'h0);
      supply5_ok <= 1'b1;
      supply12_ok <= 1'b1;
      n = 0;
      while (internal_reset !== 1'b0 && n < 20)
      begin
        @(posedge hclk);
        n++;
      end
      settle();
      xfer(0, OFS_CTRL4, 0, rv);
      check(rv, 32'h0);
      xfer(0, OFS_STATUS, 0, rv);
      check(rv, 32'h8);
    end
    tally_and_finish();
  end
endmodule : testbench

// ==== tb/tmc_far_side.sv ====
// Far side model: reference clock source and the external I/O pin wiring.
// Assumes the bench owns the external drive of the pin through ext_en/ext_level.
`timescale 1ns/10ps
module tmc_far_side
#(
  parameter int REF_NS = 80
)(
  output logic crystal_clock_pin,
  input  wire logic io_pin_out,
  input  wire logic io_pin_oe_n,
  input  wire logic ext_en,
  input  wire logic ext_level,
  output logic io_pin_in
);
  logic float_q = 1'b0;

  // ----------------------------------------------------------------
  // Reference clock, free running, phase unrelated to hclk
  // ----------------------------------------------------------------
  initial
  begin
    crystal_clock_pin = 1'b0;
    #3;
    forever #(REF_NS / 2) crystal_clock_pin = ~crystal_clock_pin;
  end

  // Undriven pin wanders so a stale level is never mistaken for a read
  always #37 float_q = ~float_q;

  // Pin level resolved from both parties' enables
  assign io_pin_in = !io_pin_oe_n ? io_pin_out : (ext_en ? ext_level : float_q);
endmodule : tmc_far_side
